/* hdl/art_timer.sv */
// Chosen here: the APB interface to the registers.
`default_nettype none
////////////////////////////////////////////////////////////////////////
module art_timer (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [art_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic ext_timer_in,
   output logic pwm_out_pin,
   // interrupt request on the shared vector
   output logic irq_vec3
);
   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] mode_control; // stored, load bit always zero
   logic [7:0] clock_edge_control; // clock, edge, prescale select
   logic [7:0] reload_capture_value; // reload or captured count
   logic [7:0] compare_value; // pwm compare
   logic [7:0] up_counter_8; // the counter
   logic [6:0] timer_prescaler; // prescaler chain
   logic [2:0] event_flags; // sticky flags
   logic [1:0] div3_cnt; // core clock divide by three
   logic pwm_level; // pwm state before output enable
   logic [1:0] pin_sync; // pin synchroniser
   logic pin_prev; // previous synced level
   art_pkg::art_events_type ev;
   ////////////////////////////////////////////////////////////////////
   // apb decode
   // every register is one aligned word, only the low byte is live
   // writes land at the access edge, never in the setup cycle,
   // so a setup cycle that is later abandoned changes nothing
   // byte lane 0 gates writes: a transfer without it is a no-op
   // unmapped words answer with an error and read back as zero
   // the low two address bits are ignored by the decoder
   wire access = psel && penable;
   wire wr = access && pwrite && pstrb[0];
   wire rd_en = access && !pwrite;
   wire [7:0] word_addr = paddr[art_pkg::ADDR_W-1:2];
   wire hit_mc = word_addr == art_pkg::IDX_MODE_CONTROL;
   wire hit_ef = word_addr == art_pkg::IDX_EVENT_FLAGS;
   wire hit_ce = word_addr == art_pkg::IDX_CLOCK_EDGE;
   wire hit_rc = word_addr == art_pkg::IDX_RELOAD_CAPTURE;
   wire hit_cp = word_addr == art_pkg::IDX_COMPARE;
   wire hit_lr = word_addr == art_pkg::IDX_COUNTER_LOAD;
   wire mapped = hit_mc | hit_ef | hit_ce | hit_rc | hit_cp | hit_lr;
   wire [7:0] wbyte = pwdata[7:0];
   ////////////////////////////////////////////////////////////////////
   // field decode
   // mode and source are kept as enums for readable comparisons
   // the reserved source code is legal to write but never ticks
   // clock settings must not change while counting: the tap
   // selector is combinational and a change mid-count may give
   // a spurious or a lost tick
   art_pkg::art_mode_type mode_field;
   art_pkg::art_src_type clock_source_select;
   assign mode_field = art_pkg::art_mode_type'(
      mode_control[art_pkg::MC_MODE_LO +: 2]);
   assign clock_source_select = art_pkg::art_src_type'(
      clock_edge_control[art_pkg::CE_CC_LO +: 2]);
   wire count_enable = mode_control[art_pkg::MC_TEN];
   wire [2:0] prescale_select = clock_edge_control[art_pkg::CE_PS_LO +: 3];
   wire edge_en = clock_edge_control[art_pkg::CE_SL0];
   wire edge_fall = clock_edge_control[art_pkg::CE_SL1];
   wire load_strobe = wr && hit_mc && wbyte[art_pkg::MC_LOAD];
   wire port_load = wr && hit_lr;
   ////////////////////////////////////////////////////////////////////
   // external pin edge detection on synchronised level
   // only the second synchroniser stage is read by logic;
   // the first may be metastable and must stay private
   // edge history resets low, matching the idle pin level,
   // so no false rising edge follows reset
   // the pin must hold each level for several core cycles,
   // otherwise a short pulse can be lost in the synchroniser
   wire pin_s = pin_sync[1];
   wire pin_rise = pin_s && !pin_prev;
   wire pin_fall = !pin_s && pin_prev;
   wire active_edge = edge_en && (edge_fall ? pin_fall : pin_rise);
   ////////////////////////////////////////////////////////////////////
   // clock multiplexer: one-cycle pulse per source rising edge
   // nothing here makes a derived clock: every source becomes a
   // single-cycle enable in the core domain, so all registers
   // stay on pclk and timing analysis sees one clock
   // the divide-by-three counter runs free, so the first tick
   // after enabling may come one or two cycles early
   wire div3_pulse = div3_cnt == art_pkg::DIV3_LAST;
   logic src_tick;
   always_comb begin
      case (clock_source_select)
         art_pkg::SRC_CORE: src_tick = 1'b1;
         art_pkg::SRC_CORE_DIV3: src_tick = div3_pulse;
         art_pkg::SRC_EXT_PIN: src_tick = pin_rise;
         default: src_tick = 1'b0; // reserved source never ticks
      endcase
   end
   // tap selector: ratio 1 uses the source, else prescaler bit n-1
   wire [7:0] taps = {timer_prescaler, 1'b0};
   wire tap_level = taps[prescale_select];
   // ratio one bypasses the prescaler entirely
   // higher ratios look ahead at the incremented prescaler and
   // tick in the cycle where the selected bit is about to rise,
   // which gives exactly one tick per 2^n source pulses
   // whatever phase the prescaler was frozen at
   wire count_tick = count_enable && src_tick &&
      (prescale_select == 3'd0 ? 1'b1 : 1'b0);
   // divided tap ticks when its bit rises after a prescaler step
   wire [6:0] psc_inc = timer_prescaler + 7'h01;
   wire [7:0] taps_next = {psc_inc, 1'b0};
   wire tap_step = count_enable && src_tick && prescale_select != 3'd0 &&
      taps_next[prescale_select] && !tap_level;
   wire adv = count_tick || tap_step;
   ////////////////////////////////////////////////////////////////////
   // counter events
   // overflow is the advance out of the top count, in every mode
   // capture and capture-with-reset share the edge detector
   // a load-port write has top priority, then the reload sources,
   // then the capture reset, then a plain count step
   // a simultaneous load and advance drops the advance: the
   // load also clears the prescaler, so the count restarts cleanly
   // a compare event needs the counter to leave the match value
   wire overflow = adv && up_counter_8 == art_pkg::COUNT_MAX;
   wire capture_mode = mode_field == art_pkg::MODE_CAPTURE ||
      mode_field == art_pkg::MODE_CAPTURE_RESET;
   wire capture_ev = capture_mode && active_edge;
   wire cap_reset = mode_field == art_pkg::MODE_CAPTURE_RESET &&
      active_edge;
   wire ext_load = mode_field == art_pkg::MODE_EXT_LOAD &&
      active_edge;
   wire auto_reload = mode_field == art_pkg::MODE_AUTO_RELOAD &&
      overflow;
   wire any_load = port_load || load_strobe || ext_load ||
      auto_reload || cap_reset;
   logic [7:0] next_counter;
   always_comb begin
      if (port_load) begin
         next_counter = wbyte;
      end else if (load_strobe || ext_load || auto_reload) begin
         next_counter = reload_capture_value;
      end else if (cap_reset) begin
         next_counter = art_pkg::RESET_BYTE;
      end else if (adv) begin
         next_counter = up_counter_8 + 8'h01;
      end else begin
         next_counter = up_counter_8;
      end
   end
   wire cmp_match = up_counter_8 == compare_value;
   wire cmp_ev = cmp_match && (cmp_match != (next_counter ==
      compare_value) || next_counter != up_counter_8);
   assign ev.ovf_ev = overflow;
   assign ev.cmp_ev = cmp_ev && next_counter != up_counter_8;
   assign ev.edge_ev = active_edge;
   ////////////////////////////////////////////////////////////////////
   // pin synchroniser and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync <= 2'h0;
         pin_prev <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[0], ext_timer_in};
         pin_prev <= pin_sync[1];
      end
   end
   // divide by three counter, free running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div3_cnt <= 2'h0;
      end else begin
         div3_cnt <= div3_pulse ? 2'h0 : div3_cnt + 2'h1;
      end
   end
   // prescaler: cleared on any load, frozen when disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_prescaler <= art_pkg::PSC_ZERO;
      end else begin
         if (any_load) begin
            timer_prescaler <= art_pkg::PSC_ZERO;
         end else if (count_enable && src_tick) begin
            timer_prescaler <= psc_inc;
         end
      end
   end
   // counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_counter_8 <= art_pkg::RESET_BYTE;
      end else begin
         up_counter_8 <= next_counter;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_control <= art_pkg::RESET_BYTE;
         clock_edge_control <= art_pkg::RESET_BYTE;
         compare_value <= art_pkg::RESET_BYTE;
      end else begin
         if (wr && hit_mc) begin
            mode_control <= {1'b0, wbyte[6:0]};
         end
         if (wr && hit_ce) begin
            clock_edge_control <= {wbyte[7:4], 1'b0, wbyte[2:0]};
         end
         if (wr && hit_cp) begin
            compare_value <= wbyte;
         end
      end
   end
   // reload/capture: capture wins over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_capture_value <= art_pkg::RESET_BYTE;
      end else if (capture_ev) begin
         reload_capture_value <= up_counter_8;
      end else if (wr && hit_rc) begin
         reload_capture_value <= wbyte;
      end
   end
   // sticky flags: set wins over clear, write one keeps bit
   // software clears by writing zero to the chosen positions;
   // an event in the same cycle as the clear survives, so no
   // event is ever lost to a read-modify-write race
   // the edge flag is set by any active edge, whatever the mode
   // flags are not cleared by the load strobe or by loads
   logic [2:0] set_vec;
   assign set_vec = {ev.edge_ev, ev.cmp_ev, ev.ovf_ev};
   logic [2:0] keep_vec;
   assign keep_vec = (wr && hit_ef) ? wbyte[2:0] : 3'h7;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_flags <= 3'h0;
      end else begin
         event_flags <= (event_flags & keep_vec) | set_vec;
      end
   end
   // pwm: overflow sets, compare match clears, in every mode
   // overflow wins when both fall in one cycle
   // the pin level is gated by the output enable bit and then
   // registered once more, so the pin comes from a flip-flop
   // the pwm state keeps running while the pin is disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_level <= 1'b0;
         pwm_out_pin <= 1'b0;
      end else begin
         if (overflow) begin
            pwm_level <= 1'b1;
         end else if (ev.cmp_ev) begin
            pwm_level <= 1'b0;
         end
         pwm_out_pin <= pwm_level && mode_control[art_pkg::MC_PWMOE];
      end
   end
   ////////////////////////////////////////////////////////////////////
   // interrupt: all enabled flags onto the one vector
   // the request is a level: it stays up until software clears
   // every enabled flag or drops the enables
   // service code must read the flags to find the cause
   // the request lags the flag by one registered cycle
   wire irq_any =
      (event_flags[art_pkg::EF_OVF] && mode_control[art_pkg::MC_OVERFLOW_IRQ_ENABLE]) ||
      (event_flags[art_pkg::EF_CPF] && mode_control[art_pkg::MC_COMPARE_IRQ_ENABLE]) ||
      (event_flags[art_pkg::EF_EDGE] && mode_control[art_pkg::MC_EIE]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_vec3 <= 1'b0;
      end else begin
         irq_vec3 <= irq_any;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // apb read mux and answer, registered, zero wait state
   // read data is latched in the setup cycle and stands through
   // the access cycle and beyond, until the next read setup
   // the counter is sampled at that setup edge, one cycle before
   // the access edge, which callers must allow for
   // the error flag is latched at the same time for any access
   // to an unmapped word, read or write alike
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_mc) rd_byte = mode_control;
      if (hit_ef) rd_byte = {5'h00, event_flags};
      if (hit_ce) rd_byte = clock_edge_control;
      if (hit_rc) rd_byte = reload_capture_value;
      if (hit_cp) rd_byte = compare_value;
      if (hit_lr) rd_byte = up_counter_8;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte}
            : prdata;
         pslverr <= psel && !penable && !mapped;
      end
   end
   // ready from a flop: always high, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b1;
      end else begin
         pready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* hdl/art_pkg.sv */
`default_nettype none
package art_pkg;
   // register word indices, byte address bits 9:2 (printed offsets are not all multiples of 4)
   localparam logic [7:0] IDX_MODE_CONTROL = 8'hD5;
   localparam logic [7:0] IDX_EVENT_FLAGS = 8'hD6;
   localparam logic [7:0] IDX_CLOCK_EDGE = 8'hD7;
   localparam logic [7:0] IDX_RELOAD_CAPTURE = 8'hD9;
   localparam logic [7:0] IDX_COMPARE = 8'hDA;
   localparam logic [7:0] IDX_COUNTER_LOAD = 8'hDB;
   localparam int ADDR_W = 10;
   // mode_control fields
   localparam int MC_MODE_LO = 0;
   localparam int MC_OVERFLOW_IRQ_ENABLE = 2;
   localparam int MC_COMPARE_IRQ_ENABLE = 3;
   localparam int MC_EIE = 4;
   localparam int MC_PWMOE = 5;
   localparam int MC_TEN = 6;
   localparam int MC_LOAD = 7;
   // event_flags fields
   localparam int EF_OVF = 0;
   localparam int EF_CPF = 1;
   localparam int EF_EDGE = 2;
   // clock_edge_control fields
   localparam int CE_PS_LO = 0;
   localparam int CE_SL0 = 4;
   localparam int CE_SL1 = 5;
   localparam int CE_CC_LO = 6;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [1:0] DIV3_LAST = 2'h2;
   localparam logic [6:0] PSC_ZERO = 7'h00;
   // interrupt vector shared by all timer events
   localparam int IRQ_VECTOR = 3;
   // operating modes
   typedef enum logic [1:0] {
      MODE_AUTO_RELOAD,
      MODE_CAPTURE,
      MODE_CAPTURE_RESET,
      MODE_EXT_LOAD
   } art_mode_type;
   // clock sources
   typedef enum logic [1:0] {
      SRC_CORE,
      SRC_CORE_DIV3,
      SRC_EXT_PIN,
      SRC_RESERVED
   } art_src_type;
   // flag set pulses carried together
   typedef struct packed {
      logic edge_ev;
      logic cmp_ev;
      logic ovf_ev;
   } art_events_type;
endpackage
`default_nettype wire

/* sim/art_monitor.sv */
`default_nettype none
//////////////////////////////////////////////////////////////
// port-level checks of the timer and its register bus
module art_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [art_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic pwm_out_pin,
   input wire logic irq_vec3
);
   // register index of the current address
   wire logic [7:0] idx = paddr[art_pkg::ADDR_W-1:2];
   // access phase of any transfer
   wire logic acc = psel && penable;
   // address hits one of the six registers
   wire logic hit = paddr[1:0] == 2'h0 && idx inside {
      art_pkg::IDX_MODE_CONTROL, art_pkg::IDX_EVENT_FLAGS,
      art_pkg::IDX_CLOCK_EDGE, art_pkg::IDX_RELOAD_CAPTURE,
      art_pkg::IDX_COMPARE, art_pkg::IDX_COUNTER_LOAD};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // read access phase
   sequence rd_s;
      acc && !pwrite;
   endsequence
   // write into the mode register
   sequence mc_wr_s;
      acc && pwrite && pstrb[0] && idx == art_pkg::IDX_MODE_CONTROL;
   endsequence
   pready_high_a: assert property (pready)
      else $error("pready low");
   upper_zero_a: assert property (acc |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   err_phase_a: assert property (pslverr |-> acc)
      else $error("pslverr outside access");
   unmapped_err_a: assert property (acc && !hit |-> pslverr)
      else $error("no error on unmapped address");
   mapped_ok_a: assert property (acc && hit |-> !pslverr)
      else $error("error on mapped address");
   bad_read_a: assert property (rd_s ##0 !hit |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   strobe_zero_a: assert property (rd_s ##0 (idx == art_pkg::IDX_MODE_CONTROL)
      |-> !prdata[art_pkg::MC_LOAD])
      else $error("load strobe reads one");
   irq_masked_a: assert property (mc_wr_s ##0 (pwdata[4:2] == 3'h0)
      |=> ##1 !irq_vec3)
      else $error("irq with all enables off");
   pwm_off_a: assert property (mc_wr_s ##0 !pwdata[art_pkg::MC_PWMOE]
      |=> ##1 !pwm_out_pin)
      else $error("pwm pin driven while disabled");
   reset_quiet_a: assert property ($rose(presetn)
      |-> !pwm_out_pin && !irq_vec3)
      else $error("outputs active after reset");
endmodule
bind art_timer art_monitor MON (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pwm_out_pin(pwm_out_pin), .irq_vec3(irq_vec3));
`default_nettype wire

/* sim/art_pin_model.sv */
`default_nettype none
//////////////////////////////////////////////////////////////
// far side: drives the timer input pin, times the pwm pin
module art_pin_model (
   // clock
   input wire logic pclk,
   // pins
   output logic ext_timer_in,
   input wire logic pwm_out_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] period_len = 16'h0000; // last full pwm period
   logic [15:0] high_len = 16'h0000; // last pwm high time
   logic [15:0] run = 16'h0000; // cycles since last rise
   logic pwm_q = 1'b0; // pwm level one cycle ago
   initial ext_timer_in = 1'b0;
   // measure pwm high time and period in core cycles
   always @(posedge pclk) begin
      pwm_q <= pwm_out_pin;
      run <= (pwm_out_pin && !pwm_q) ? 16'h0001 : run + 16'h0001;
      if (pwm_out_pin && !pwm_q) period_len <= run;
      if (!pwm_out_pin && pwm_q) high_len <= run;
   end
   // one level change, held four cycles for the synchroniser
   task automatic drive(input logic v);
      @(posedge pclk);
      ext_timer_in <= v;
      repeat (4) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
`default_nettype none
//////////////////////////////////////////////////////////////
// register-level tests of the timer
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MC = art_pkg::IDX_MODE_CONTROL;
   localparam logic [7:0] EF = art_pkg::IDX_EVENT_FLAGS;
   localparam logic [7:0] CE = art_pkg::IDX_CLOCK_EDGE;
   localparam logic [7:0] RC = art_pkg::IDX_RELOAD_CAPTURE;
   localparam logic [7:0] CP = art_pkg::IDX_COMPARE;
   localparam logic [7:0] LD = art_pkg::IDX_COUNTER_LOAD;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [9:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb; // lane 0 gates writes
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_timer_in;
   logic pwm_out_pin;
   logic irq_vec3;
   logic [31:0] rd; // data of the last read
   logic [7:0] a; // first counter sample
   logic [7:0] regs [6] = '{MC, EF, CE, RC, CP, LD};
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   art_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_timer_in(ext_timer_in), .pwm_out_pin(pwm_out_pin),
      .irq_vec3(irq_vec3));
   art_pin_model PIN (.pclk(pclk), .ext_timer_in(ext_timer_in),
      .pwm_out_pin(pwm_out_pin));
   // 50 MHz core clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         finish_test();
      end
   end
   // one apb transfer: setup, access until pready
   task automatic xfer(input logic w, input logic [7:0] i,
                       input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n == 50) failures++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // value compare
   task automatic check(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      xfer(1'b1, i, d);
   endtask
   // read a register and compare its low byte
   task automatic rd_chk(input string nm, input logic [7:0] i,
                         input logic [7:0] e);
      xfer(1'b0, i, 8'h00);
      check(nm, {8'h00, e}, {8'h00, rd[7:0]});
   endtask
   // wait for the irq register, then compare it
   task automatic irq_chk(input logic e);
      repeat (3) @(posedge pclk);
      check("irq", {15'h0, e}, {15'h0, irq_vec3});
   endtask
   // verdict
   task automatic finish_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd_chk("reset", regs[i], 8'h00);
      end
      rd_chk("unmapped", 8'hD8, 8'h00);
      // a write without byte lane 0 must not land
      pstrb <= 4'hE;
      wr(LD, 8'hA5);
      pstrb <= 4'hF;
      rd_chk("masked", LD, 8'h00);
      wr(LD, 8'h5A);
      rd_chk("load", LD, 8'h5A);
      // every tap, then the divide-by-3 source
      for (int k = 0; k < 9; k++) begin
         wr(MC, 8'h00);
         wr(CE, k < 8 ? 8'(k) : 8'h40);
         wr(MC, 8'h40);
         xfer(1'b0, LD, 8'h00);
         a = rd[7:0];
         repeat (k < 8 ? (4 << k) - 3 : 3) @(posedge pclk);
         rd_chk("count", LD, a + (k < 8 ? 8'h04 : 8'h02));
      end
      // auto-reload pwm, reload then strobe
      wr(MC, 8'h00);
      wr(CE, 8'h00);
      wr(RC, 8'hF0);
      wr(CP, 8'hF8);
      wr(MC, 8'hE4);
      rd_chk("strobe", MC, 8'h64);
      repeat (40) @(posedge pclk);
      check("period", 16'd16, PIN.period_len);
      check("high", 16'd9, PIN.high_len);
      rd_chk("flags", EF, 8'h03);
      irq_chk(1'b1);
      wr(MC, 8'h24);
      wr(EF, 8'hFF);
      rd_chk("flags", EF, 8'h03);
      wr(EF, 8'hFE);
      rd_chk("flags", EF, 8'h02);
      irq_chk(1'b0);
      wr(MC, 8'h08);
      irq_chk(1'b1);
      wr(EF, 8'h00);
      irq_chk(1'b0);
      // capture on rising, then falling, then disabled
      wr(MC, 8'h11);
      wr(LD, 8'h33);
      wr(CE, 8'h10);
      wr(EF, 8'h00);
      PIN.drive(1'b1);
      rd_chk("capture", RC, 8'h33);
      rd_chk("flags", EF, 8'h04);
      irq_chk(1'b1);
      wr(CE, 8'h30);
      wr(LD, 8'h44);
      PIN.drive(1'b0);
      wr(LD, 8'h45);
      PIN.drive(1'b1);
      rd_chk("capture", RC, 8'h44);
      wr(CE, 8'h20);
      PIN.drive(1'b0);
      rd_chk("capture", RC, 8'h44);
      // capture with reset
      wr(MC, 8'h02);
      wr(CE, 8'h10);
      wr(LD, 8'h66);
      PIN.drive(1'b1);
      rd_chk("capture", RC, 8'h66);
      rd_chk("counter", LD, 8'h00);
      // load on external edge, counter stopped
      wr(MC, 8'h03);
      wr(RC, 8'h77);
      wr(LD, 8'h12);
      PIN.drive(1'b0);
      PIN.drive(1'b1);
      rd_chk("counter", LD, 8'h77);
      // pin as clock source, auto-reload only
      wr(MC, 8'h00);
      wr(CE, 8'h80);
      wr(LD, 8'h00);
      wr(MC, 8'h40);
      repeat (5) begin
         PIN.drive(1'b0);
         PIN.drive(1'b1);
      end
      wr(MC, 8'h00);
      rd_chk("counter", LD, 8'h05);
      finish_test();
   end
endmodule
`default_nettype wire
